// ### dv/aigc_config_checker.sv
// Concurrent checks on the configuration register ports
module aigc_config_checker (
  input logic core_clk,
  input logic rst,
  input logic [7:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [12:0] positive_input_select,
  input logic [12:0] negative_input_select,
  input logic amplifier_powered,
  input logic amplifier_bypassed,
  input logic [7:0] amplifier_gain
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_reset_state: assert property (disable iff (1'b0) rst |=> avs_waitrequest &&
    positive_input_select == 13'h0001 && negative_input_select == 13'h0002)
    else $error("reset state wrong");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("access not answered in one cycle");
  chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_select_onehot: assert property ($onehot0(positive_input_select) &&
    $onehot0(negative_input_select)) else $error("input select not one-hot");
  chk_amp_mode: assert property (amplifier_powered != amplifier_bypassed)
    else $error("amplifier mode ambiguous");
  chk_bypass_unity: assert property (amplifier_bypassed |-> amplifier_gain == 8'h01)
    else $error("bypass without unity gain");
  chk_gain_max: assert property (avs_write && !avs_waitrequest && avs_address == 8'h03 &&
    avs_byteenable[0] && avs_writedata[4:0] == 5'h0F |-> ##[1:2] amplifier_gain == 8'h80)
    else $error("gain code 7 not 128");
  chk_neg_common: assert property (avs_write && !avs_waitrequest && avs_address == 8'h02 &&
    avs_byteenable[0] && avs_writedata[7:0] == 8'h3C |-> ##[1:2]
    negative_input_select == 13'h1000 && positive_input_select == 13'h0008)
    else $error("common pin not selected");
endmodule // aigc_config_checker
bind aigc_config aigc_config_checker i_chk (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .positive_input_select,
  .negative_input_select, .amplifier_powered, .amplifier_bypassed, .amplifier_gain);

// ### dv/tb.sv
// Testbench for the input and gain configuration registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic amplifier_powered, amplifier_bypassed, config_fault;
  logic [7:0] avs_address = 8'h00, amplifier_gain;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [12:0] positive_input_select, negative_input_select;
  int failures = 0, comparisons = 0;
  // Address, write value, expected read back; 10h is unmapped
  // Reserved gain bits always written as zero by software
  logic [7:0] rows [4][3] = '{'{8'h02, 8'hA5, 8'hA5}, '{8'h03, 8'h08, 8'h08},
    '{8'h03, 8'h0F, 8'h0F}, '{8'h10, 8'h5A, 8'h00}};
  aigc_config i_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .positive_input_select,
    .negative_input_select, .amplifier_powered, .amplifier_bypassed, .amplifier_gain,
    .config_fault);
  always #4 core_clk = ~core_clk;
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A gap cycle before each access keeps drivers to one update per step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    cmp(positive_input_select, 32'h1);
    cmp(negative_input_select, 32'h2);
    cmp(amplifier_bypassed, 32'h1);
    cmp(config_fault, 32'h0);
    bus(1'b0, 8'h02, 8'h00, 4'hF);
    cmp(rd, 32'h01);
    bus(1'b0, 8'h03, 8'h00, 4'hF);
    cmp(rd, 32'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][0], rows[i][1], 4'hF);
      bus(1'b0, rows[i][0], 8'h00, 4'hF);
      cmp(rd, rows[i][2]);
    end
    $display("register rows done");
    // Codes six and up used only because the default build is the wide part
    for (int k = 0; k < 12; k++) begin
      wr_wait(8'h02, {k[3:0], k[3:0]});
      cmp(positive_input_select, 32'h1 << k);
      cmp(negative_input_select, 32'h1 << k);
    end
    wr_wait(8'h02, 8'h3C);
    cmp(negative_input_select, 32'h1000);
    $display("input select done");
    // Enable field only ever 00 or 01
    for (int k = 0; k < 8; k++) begin
      wr_wait(8'h03, {5'h01, k[2:0]});
      cmp({amplifier_powered, amplifier_gain}, 32'h100 | (32'h1 << k));
    end
    wr_wait(8'h03, 8'h00);
    cmp({amplifier_bypassed, amplifier_gain}, 32'h101);
    bus(1'b1, 8'h03, 8'h0F, 4'hE);
    bus(1'b0, 8'h03, 8'h00, 4'hF);
    cmp(rd, 32'h00);
    $display("gain and lane checks done");
    wr_wait(8'h02, 8'hD1);
    cmp(positive_input_select, 32'h0);
    cmp(config_fault, 32'h1);
    wr_wait(8'h02, 8'h5A);
    cmp(config_fault, 32'h0);
    wr_wait(8'h03, 8'h0B);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    cmp(positive_input_select, 32'h1);
    cmp(negative_input_select, 32'h2);
    cmp({amplifier_powered, amplifier_bypassed, amplifier_gain}, 32'h101);
    bus(1'b0, 8'h02, 8'h00, 4'hF);
    cmp(rd, 32'h01);
    bus(1'b0, 8'h03, 8'h00, 4'hF);
    cmp(rd, 32'h00);
    $display("fault and mid-run reset checks done");
    wrap_up();
  end
endmodule // tb

// ### include/aigc_defines.vh
// Register offsets, field positions and reset values for input and gain configuration
`ifndef AIGC_DEFINES_VH
`define AIGC_DEFINES_VH

`define AIGC_ADDR_W 8
`define AIGC_OFS_INPUT_CHANNEL_SELECT 8'h02
`define AIGC_OFS_AMPLIFIER_GAIN_SETTING 8'h03
`define AIGC_OFS_FRONT_END_STATUS 8'h20
`define AIGC_RST_INPUT_CHANNEL_SELECT 8'h01
`define AIGC_RST_AMPLIFIER_GAIN_SETTING 8'h00
`define AIGC_POS_MSB 7
`define AIGC_POS_LSB 4
`define AIGC_NEG_MSB 3
`define AIGC_NEG_LSB 0
`define AIGC_EN_MSB 4
`define AIGC_EN_LSB 3
`define AIGC_GAIN_MSB 2
`define AIGC_GAIN_LSB 0
`define AIGC_EN_BYPASS 2'h0
`define AIGC_EN_ACTIVE 2'h1
`define AIGC_CODE_LAST_AIN 4'hB
`define AIGC_CODE_COMMON 4'hC
`define AIGC_CODE_FIRST_WIDE 4'h6
`define AIGC_READ_LATENCY 1

`endif

// ### verilog/aigc_config.v
// Input multiplexer and gain amplifier configuration registers on Avalon-MM
// Operation
// R1: Bits 7:4 of channel select pick positive input; codes 0-11 map inputs 0-11.
// R2: Positive selection resets to code 0000, analog input zero.
// R3: Bits 3:0 pick negative input; codes 0-11 inputs, 1100 common pin.
// R4: Negative selection resets to code 0001, analog input one.
// R5: Software uses codes 0110-1011 only on the twelve-channel variant.
// R6: Gain register at 03h, resets to all zeros, amplifier bypassed.
// R7: Enable field 00 powers down amplifier and bypasses it.
// R8: Enable field 01 powers amplifier and applies programmed gain 1 to 128.
// R9: Software never writes reserved enable codes 10 or 11.
// R10: Gain field bits 2:0 select gain two to the code power.
// R11: Software sets gain code 000 whenever bypass is chosen.
// R12: Channel select register at 02h, resets to 01h.
// R13: Reserved upper gain bits read back exactly as written.
`include "aigc_defines.vh"
module aigc_config #(
  parameter WIDE_VARIANT = 1
) (
  input wire core_clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [12:0] positive_input_select,
  output reg [12:0] negative_input_select,
  output reg amplifier_powered,
  output reg amplifier_bypassed,
  output reg [7:0] amplifier_gain,
  output reg config_fault
);
  reg [7:0] input_channel_select_reg;
  reg [7:0] amplifier_gain_setting_reg;
  reg [7:0] input_channel_select_next;
  reg [7:0] amplifier_gain_setting_next;
  reg done_reg;
  wire [12:0] pos_onehot;
  wire [12:0] neg_onehot;
  wire pos_valid;
  wire neg_valid;
  wire [1:0] en_field;
  wire [2:0] gain_field;
  wire access;
  wire wr_lane0;

  // One wait cycle per access keeps read data registered
  assign access = (avs_read || avs_write) && !done_reg;
  assign wr_lane0 = avs_write && !done_reg && avs_byteenable[0];
  assign en_field = amplifier_gain_setting_reg[`AIGC_EN_MSB:`AIGC_EN_LSB];
  assign gain_field = amplifier_gain_setting_reg[`AIGC_GAIN_MSB:`AIGC_GAIN_LSB];

  aigc_input_decode u_pos (
    .code(input_channel_select_reg[`AIGC_POS_MSB:`AIGC_POS_LSB]), // see R1
    .allow_common(1'b0),
    .wide_variant(WIDE_VARIANT != 0),
    .select_onehot(pos_onehot),
    .code_valid(pos_valid)
  );

  aigc_input_decode u_neg (
    .code(input_channel_select_reg[`AIGC_NEG_MSB:`AIGC_NEG_LSB]), // see R3
    .allow_common(1'b1),
    .wide_variant(WIDE_VARIANT != 0),
    .select_onehot(neg_onehot),
    .code_valid(neg_valid)
  );

  always @* begin
    input_channel_select_next = input_channel_select_reg;
    amplifier_gain_setting_next = amplifier_gain_setting_reg;
    if (wr_lane0 && avs_address == `AIGC_OFS_INPUT_CHANNEL_SELECT) begin
      input_channel_select_next = avs_writedata[7:0]; // see R12
    end
    if (wr_lane0 && avs_address == `AIGC_OFS_AMPLIFIER_GAIN_SETTING) begin
      // Reserved bits stored too, so they read back as written
      amplifier_gain_setting_next = avs_writedata[7:0]; // see R13
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      input_channel_select_reg <= `AIGC_RST_INPUT_CHANNEL_SELECT; // see R2 see R4 see R12
      amplifier_gain_setting_reg <= `AIGC_RST_AMPLIFIER_GAIN_SETTING; // see R6
      done_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      input_channel_select_reg <= input_channel_select_next;
      amplifier_gain_setting_reg <= amplifier_gain_setting_next;
      done_reg <= access;
      avs_waitrequest <= !access;
      if (access && avs_read) begin
        case (avs_address)
          `AIGC_OFS_INPUT_CHANNEL_SELECT: begin
            avs_readdata <= {24'h000000, input_channel_select_reg};
          end
          `AIGC_OFS_AMPLIFIER_GAIN_SETTING: begin
            avs_readdata <= {24'h000000, amplifier_gain_setting_reg}; // see R6
          end
          `AIGC_OFS_FRONT_END_STATUS: begin
            avs_readdata <= {28'h0000000, amplifier_bypassed, amplifier_powered,
                             neg_valid, pos_valid};
          end
          default: begin
            // Unmapped offsets answer with zero
            avs_readdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Front-end controls follow the registers one cycle later
  always @(posedge core_clk) begin
    if (rst) begin
      positive_input_select <= 13'h0001;
      negative_input_select <= 13'h0002;
      amplifier_powered <= 1'b0;
      amplifier_bypassed <= 1'b1;
      amplifier_gain <= 8'h01;
      config_fault <= 1'b0;
    end else begin
      positive_input_select <= pos_onehot; // see R1
      negative_input_select <= neg_onehot; // see R3
      case (en_field)
        `AIGC_EN_BYPASS: begin
          amplifier_powered <= 1'b0; // see R7
          amplifier_bypassed <= 1'b1;
          // Bypass forces unity even if gain field was left nonzero
          amplifier_gain <= 8'h01;
        end
        `AIGC_EN_ACTIVE: begin
          amplifier_powered <= 1'b1; // see R8
          amplifier_bypassed <= 1'b0;
          amplifier_gain <= 8'h01 << gain_field; // see R10
        end
        default: begin
          // Reserved enable codes: safe bypass state
          amplifier_powered <= 1'b0;
          amplifier_bypassed <= 1'b1;
          amplifier_gain <= 8'h01;
        end
      endcase
      // Flags misuse by software: unmapped code, reserved enable, bypass gain
      config_fault <= !pos_valid || !neg_valid || en_field[1] // see R5 see R9
        || (en_field == `AIGC_EN_BYPASS && gain_field != 3'h0); // see R11
    end
  end
endmodule // aigc_config

// ### verilog/aigc_input_decode.v
// Decodes an input selection code into a one-hot analog channel select
module aigc_input_decode (
  input wire [3:0] code,
  input wire allow_common,
  input wire wide_variant,
  output wire [12:0] select_onehot,
  output wire code_valid
);
  genvar i;
  generate
    for (i = 0; i < 12; i = i + 1) begin : g_ain
      // Inputs six and up exist only on the wide part
      assign select_onehot[i] = (code == i) && (wide_variant || (i < 6));
    end
  endgenerate
  assign select_onehot[12] = allow_common && (code == `AIGC_CODE_COMMON);
  assign code_valid = |select_onehot;
endmodule // aigc_input_decode
